// File: fcp_core.sv
`timescale 1ns/1ps
`default_nettype none
module fcp_core import fcp_pkg::*; #(
  parameter bit QR_VARIANT = 1'b1,
  parameter int SS_STEP_CYC = SS_STEP_DEF,
  parameter int OVL_CYC = OVL_DEF,
  parameter int EXT_CYC = EXT_DEF,
  parameter int JIT_STEP_CYC = JIT_STEP_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supplyGood,
  input wire logic underVoltage,
  input wire logic fbBelowGreenEntry,
  input wire logic fbAboveGreenExit,
  input wire logic fbBelowBurstEntry,
  input wire logic fbAboveBurstExit,
  input wire logic fbAboveOverload,
  input wire logic csAbovePeakLimit,
  input wire logic csAboveExtThermal,
  input wire logic csAboveRectShort,
  input wire logic plateauOvervolt,
  input wire logic valleyDetect,
  input wire logic lineHighDetect,
  input wire logic dieHot,
  input wire logic dieCooled,
  output logic gateDrive,
  output logic [3:0] peakLimitStep,
  output logic lineHighSel,
  output logic slopeEnable,
  output logic faultLatched,
  output logic dieFault
);
  // All state of the controller in one record.
  typedef struct packed {
    logic [IN_W-1:0] syncA;
    logic [IN_W-1:0] syncB;
    logic dieCoolA;
    logic dieCoolB;
    fcp_state_e st;
    fcp_mode_e mode;
    logic lineHigh;
    logic [11:0] phase;
    logic [11:0] pfmExtra;
    logic gate;
    logic [4:0] blank;
    logic waitValley;
    logic [7:0] hold;
    logic [CNT_W-1:0] ssCnt;
    logic [3:0] ssStep;
    logic [CNT_W-1:0] ovlCnt;
    logic [CNT_W-1:0] extCnt;
    logic [CNT_W-1:0] jitCnt;
    logic [6:0] jitOff;
    logic jitUp;
    logic sawPlateau;
    logic sawShort;
    logic [2:0] ovpRun;
    logic [2:0] rsRun;
    logic dieFault;
    logic slope;
    logic fault;
  } fcp_core_s;

  fcp_core_s cur; // Registered state.
  fcp_core_s next_cur; // Value for the next edge.

  // Share of a period in cycles, used for the duty ceiling and the ramp start.
  function automatic logic [11:0] pctOf(input logic [11:0] per, input logic [6:0] pct);
    logic [18:0] prod;
    prod = per * pct;
    pctOf = 12'(prod / 19'd100);
  endfunction

  logic [IN_W-1:0] rawIn; // Comparator levels before synchronising.
  logic [IN_W-1:0] s; // Synchronised comparator levels.
  logic running; // Sequencer allows switching.
  logic canSwitch; // A pulse may be issued now.
  logic [11:0] period; // Present switching period.
  logic periodEnd; // Oscillator has reached the period end.
  logic turnOn; // A new switching cycle starts at this edge.
  logic csLive; // Current sense is past blanking.

  assign rawIn = {dieHot, lineHighDetect, valleyDetect, plateauOvervolt, csAboveRectShort,
                  csAboveExtThermal, csAbovePeakLimit, fbAboveOverload, fbAboveBurstExit,
                  fbBelowBurstEntry, fbAboveGreenExit, fbBelowGreenEntry, underVoltage,
                  supplyGood};
  assign s = cur.syncB;
  assign running = (cur.st == ST_SOFT) || (cur.st == ST_RUN);
  assign canSwitch = running && (cur.mode != MD_BURST) && !cur.dieFault && !s[I_UNDERV];
  assign csLive = (cur.blank == 5'h0);

  // Period from line level, jitter and PFM stretch, never longer than the floor frequency.
  always_comb begin
    logic [12:0] sum;
    sum = 13'h0000;
    sum = {1'b0, (cur.lineHigh ? PER_HIGH : PER_LOW)};
    sum = sum + 13'(cur.jitOff) - 13'(JIT_SPAN);
    sum = sum + {1'b0, cur.pfmExtra};
    if (sum > {1'b0, PER_MIN_FREQ}) begin
      period = PER_MIN_FREQ;
    end else begin
      period = sum[11:0];
    end
  end

  assign periodEnd = (cur.phase >= period - 12'h001);
  // valley or hold timeout in the QR build, oscillator alone otherwise.
  assign turnOn = QR_VARIANT ? (cur.waitValley && (s[I_VALLEY] || cur.hold >= HOLD_CYC))
                             : periodEnd;

  // Next-state logic for the whole controller.
  always_comb begin
    next_cur = cur;
    // The first stage feeds only the second stage.
    next_cur.syncA = rawIn;
    next_cur.syncB = cur.syncA;
    next_cur.dieCoolA = dieCooled;
    next_cur.dieCoolB = cur.dieCoolA;

    // Oscillator phase, frozen while waiting for a valley.
    if (!cur.waitValley) begin
      next_cur.phase = cur.phase + 12'h001;
    end
    if (QR_VARIANT && periodEnd && !cur.waitValley) begin
      next_cur.waitValley = 1'b1;
      next_cur.hold = 8'h00;
    end else if (cur.waitValley) begin
      next_cur.hold = cur.hold + 8'h01;
    end
    if (cur.blank != 5'h0) begin
      next_cur.blank = cur.blank - 5'h01;
    end

    // Off-time plateau sampling and on-time short detection for the per-cycle counters.
    if (!cur.gate && s[I_PLATEAU]) begin
      next_cur.sawPlateau = 1'b1;
    end
    if (cur.gate && csLive && s[I_SHORT]) begin
      next_cur.sawShort = 1'b1;
    end

    // peak cut after blanking; duty ceiling also ends the pulse.
    if (cur.gate && ((csLive && s[I_PEAK]) || cur.phase >= pctOf(period, DUTY_MAX_PCT))) begin
      next_cur.gate = 1'b0;
    end
    if (!canSwitch) begin
      next_cur.gate = 1'b0;
    end

    next_cur.slope = cur.gate && (cur.phase >= pctOf(period, SLOPE_PCT));

    // Start of a switching cycle.
    if (turnOn) begin
      next_cur.phase = 12'h000;
      next_cur.waitValley = 1'b0;
      next_cur.gate = canSwitch;
      next_cur.blank = canSwitch ? BLANK_CYC : 5'h00;
      next_cur.lineHigh = s[I_LINE];
      next_cur.ovpRun = cur.sawPlateau ? cur.ovpRun + 3'h1 : 3'h0;
      next_cur.rsRun = cur.sawShort ? cur.rsRun + 3'h1 : 3'h0;
      next_cur.sawPlateau = 1'b0;
      next_cur.sawShort = 1'b0;
      if (cur.mode == MD_PFM && s[I_GREEN_IN]) begin
        if (period < PER_MIN_FREQ) begin
          next_cur.pfmExtra = cur.pfmExtra + PFM_STEP;
        end
      end else if (cur.mode != MD_BURST && cur.pfmExtra >= PFM_STEP) begin
        next_cur.pfmExtra = cur.pfmExtra - PFM_STEP;
      end
    end

    // Triangle jitter sweep.
    if (cur.jitCnt >= CNT_W'(JIT_STEP_CYC - 1)) begin
      next_cur.jitCnt = '0;
      if (cur.jitUp) begin
        next_cur.jitOff = cur.jitOff + 7'h01;
        next_cur.jitUp = (cur.jitOff + 7'h01) < {JIT_SPAN[5:0], 1'b0};
      end else begin
        next_cur.jitOff = cur.jitOff - 7'h01;
        next_cur.jitUp = (cur.jitOff - 7'h01) == 7'h00;
      end
    end else begin
      next_cur.jitCnt = cur.jitCnt + CNT_W'(1);
    end

    // green mode hysteresis; burst exit hysteresis.
    unique case (cur.mode)
      MD_FIXED: begin
        if (s[I_BURST_IN]) begin
          next_cur.mode = MD_BURST;
        end else if (s[I_GREEN_IN]) begin
          next_cur.mode = MD_PFM;
        end
      end
      MD_PFM: begin
        if (s[I_BURST_IN]) begin
          next_cur.mode = MD_BURST;
        end else if (s[I_GREEN_OUT]) begin
          next_cur.mode = MD_FIXED;
        end
      end
      MD_BURST: begin
        if (s[I_BURST_OUT]) begin
          next_cur.mode = MD_PFM;
        end
      end
      default: begin
        next_cur.mode = MD_FIXED;
      end
    endcase

    next_cur.ovlCnt = s[I_OVERLOAD] ? cur.ovlCnt + CNT_W'(1) : '0;
    next_cur.extCnt = s[I_EXT_HOT] ? cur.extCnt + CNT_W'(1) : '0;
    if (!running) begin
      next_cur.ovlCnt = '0;
      next_cur.extCnt = '0;
    end

    // die fault follows the hot flag and clears only on the cooled flag; hot wins.
    if (s[I_DIE_HOT]) begin
      next_cur.dieFault = 1'b1;
    end else if (cur.dieCoolB) begin
      next_cur.dieFault = 1'b0;
    end

    // Start-up sequencer.
    unique case (cur.st)
      ST_IDLE: begin
        next_cur.gate = 1'b0;
        if (s[I_SUPPLY] && !s[I_UNDERV]) begin
          next_cur.st = ST_SOFT;
          next_cur.ssCnt = '0;
          next_cur.ssStep = 4'h0;
        end
      end
      ST_SOFT: begin
        if (cur.ssCnt >= CNT_W'(SS_STEP_CYC - 1)) begin
          next_cur.ssCnt = '0;
          next_cur.ssStep = cur.ssStep + 4'h1;
          if (cur.ssStep == 4'he) begin
            next_cur.st = ST_RUN;
          end
        end else begin
          next_cur.ssCnt = cur.ssCnt + CNT_W'(1);
        end
      end
      ST_RUN: begin
        next_cur.ssStep = 4'hf;
      end
      ST_FAULT: begin
        next_cur.gate = 1'b0;
      end
    endcase

    // protection trips latch the fault state.
    if (running && ((turnOn && cur.sawPlateau && cur.ovpRun == TRIP_CYCLES - 3'h1) ||
                    (turnOn && cur.sawShort && cur.rsRun == TRIP_CYCLES - 3'h1) ||
                    cur.ovlCnt >= CNT_W'(OVL_CYC) || cur.extCnt >= CNT_W'(EXT_CYC))) begin
      next_cur.st = ST_FAULT;
      next_cur.gate = 1'b0;
    end

    // undervoltage returns to idle from any state.
    if (s[I_UNDERV] && cur.st != ST_IDLE) begin
      next_cur.st = ST_IDLE;
      next_cur.gate = 1'b0;
      next_cur.mode = MD_FIXED;
      next_cur.pfmExtra = 12'h000;
      next_cur.ovpRun = 3'h0;
      next_cur.rsRun = 3'h0;
      next_cur.ssStep = 4'h0;
    end
    next_cur.fault = (next_cur.st == ST_FAULT);
  end

  // State register; every field resets to a constant.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs come straight from state flops.
  assign gateDrive = cur.gate;
  assign peakLimitStep = cur.ssStep;
  assign lineHighSel = cur.lineHigh;
  assign slopeEnable = cur.slope;
  assign faultLatched = cur.fault;
  assign dieFault = cur.dieFault;

  a_idle_gate: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.st == ST_IDLE && $past(cur.st) == ST_IDLE) |-> !cur.gate)
    else $error("Gate high while idle.");
  a_uv_stop: assert property (@(posedge clk) disable iff (!arst_n)
    (s[I_UNDERV] && cur.st != ST_IDLE) |=> (cur.st == ST_IDLE && !cur.gate))
    else $error("Undervoltage did not stop switching.");
  a_soft_rise: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.st == ST_SOFT && $past(cur.st) == ST_SOFT) |-> cur.ssStep >= $past(cur.ssStep))
    else $error("Soft-start step fell.");
  a_freq_floor: assert property (@(posedge clk) disable iff (!arst_n)
    period <= PER_MIN_FREQ)
    else $error("Period beyond floor frequency.");
  a_burst_off: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.mode == MD_BURST && $past(cur.mode) == MD_BURST) |-> !cur.gate)
    else $error("Gate switched in burst.");
  a_burst_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.mode == MD_BURST && !s[I_BURST_OUT] && !s[I_UNDERV]) |=> cur.mode == MD_BURST)
    else $error("Burst left below exit level.");
  a_plateau_trip: assert property (@(posedge clk) disable iff (!arst_n)
    (running && turnOn && cur.sawPlateau && cur.ovpRun == 3'h6 && !s[I_UNDERV])
      |=> (cur.st == ST_FAULT && !cur.gate))
    else $error("Plateau overvoltage did not trip.");
  a_short_trip: assert property (@(posedge clk) disable iff (!arst_n)
    (running && turnOn && cur.sawShort && cur.rsRun == 3'h6 && !s[I_UNDERV])
      |=> cur.st == ST_FAULT)
    else $error("Rectifier short did not trip.");
  a_peak_cut: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.gate && csLive && s[I_PEAK] && !turnOn) |=> !cur.gate)
    else $error("Peak limit did not end pulse.");
  a_blank_keep: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.gate && cur.blank > 5'h1 && canSwitch && !s[I_OVERLOAD]) ##1 canSwitch
      |-> cur.gate)
    else $error("Pulse ended inside blanking.");
  a_fault_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (cur.st == ST_FAULT && !s[I_UNDERV]) |=> (cur.st == ST_FAULT && !cur.gate))
    else $error("Fault state released without undervoltage.");
  a_die_set: assert property (@(posedge clk) disable iff (!arst_n)
    s[I_DIE_HOT] |=> cur.dieFault)
    else $error("Die hot flag missed.");
endmodule
`default_nettype wire

// File: fcp_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: drives sense levels, times the gate and checks protections.
module fcp_core_tb_top import fcp_pkg::*;;
  // Reduced counts keep the run short; the soft-start and debounce expectations are derived from them.
  localparam int SS_C = 20;
  localparam int OVL_C = 50;
  localparam int EXT_C = 40;
  logic clk, arst_n, supplyGood, underVoltage, fbBelowGreenEntry, fbAboveGreenExit;
  logic fbBelowBurstEntry, fbAboveBurstExit, fbAboveOverload, csAbovePeakLimit;
  logic csAboveExtThermal, csAboveRectShort, plateauOvervolt, valleyDetect, valleyOn;
  logic lineHighDetect, dieHot, dieCooled, gateDrive, lineHighSel, slopeEnable;
  logic faultLatched, dieFault;
  logic [3:0] peakLimitStep;
  logic [7:0] peakDelay;
  int errors, n_checks, onT, per, slopeAt, hi;

  fcp_core #(.QR_VARIANT(1'b1), .SS_STEP_CYC(SS_C), .OVL_CYC(OVL_C), .EXT_CYC(EXT_C),
    .JIT_STEP_CYC(4)) u_fcp_core (.clk(clk), .arst_n(arst_n), .supplyGood(supplyGood),
    .underVoltage(underVoltage), .fbBelowGreenEntry(fbBelowGreenEntry),
    .fbAboveGreenExit(fbAboveGreenExit), .fbBelowBurstEntry(fbBelowBurstEntry),
    .fbAboveBurstExit(fbAboveBurstExit), .fbAboveOverload(fbAboveOverload),
    .csAbovePeakLimit(csAbovePeakLimit), .csAboveExtThermal(csAboveExtThermal),
    .csAboveRectShort(csAboveRectShort), .plateauOvervolt(plateauOvervolt),
    .valleyDetect(valleyDetect), .lineHighDetect(lineHighDetect), .dieHot(dieHot),
    .dieCooled(dieCooled), .gateDrive(gateDrive), .peakLimitStep(peakLimitStep),
    .lineHighSel(lineHighSel), .slopeEnable(slopeEnable), .faultLatched(faultLatched),
    .dieFault(dieFault));
  fcp_switch_model u_fcp_switch_model (.clk(clk), .arst_n(arst_n), .gateDrive(gateDrive),
    .peakDelay(peakDelay), .valleyOn(valleyOn), .csAbovePeakLimit(csAbovePeakLimit),
    .valleyDetect(valleyDetect));

  // Free-running 40 MHz core clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Exact comparison of a flag or the step code.
  task automatic chk_val(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // Comparison of a measured cycle count against a window.
  task automatic chk_range(input string what, input int lo, input int up, input int got);
    n_checks++;
    if (got < lo || got > up) begin
      errors++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, up, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Counts the gate's high cycles over a window.
  task automatic quiet(input int n, output int h);
    h = 0;
    repeat (n) begin
      cyc(1);
      if (gateDrive !== 1'b0) h++;
    end
  endtask

  // Times one cycle from turn-on to turn-on; a missing edge ends the run.
  task automatic measure();
    int n;
    n = 0;
    onT = 0;
    slopeAt = 0;
    while (gateDrive !== 1'b0 && n < 4000) begin cyc(1); n++; end
    while (gateDrive !== 1'b1 && n < 4000) begin cyc(1); n++; end
    while (gateDrive === 1'b1 && n < 4000) begin
      if (slopeEnable === 1'b1 && slopeAt == 0) slopeAt = onT;
      cyc(1);
      onT++;
      n++;
    end
    per = onT;
    while (gateDrive !== 1'b1 && n < 4000) begin cyc(1); per++; n++; end
    if (n >= 4000) begin
      errors++;
      $display("unexpected gate edge: expected within 4000, seen none");
      finish_test();
    end
  endtask

  // Waits for the peak limit to reach full scale and times the ramp.
  task automatic soft_start();
    int n;
    n = 0;
    while (peakLimitStep !== 4'hf && n < 20 * SS_C) begin cyc(1); n++; end
    chk_range("soft start cycles", 15 * SS_C, 16 * SS_C + 8, n);
    // A ramp that never completes cannot be judged further.
    if (n >= 20 * SS_C) begin
      finish_test();
    end
  endtask

  // Undervoltage drops everything to idle, then a fresh start follows.
  task automatic restart();
    @(posedge clk);
    underVoltage <= 1'b1;
    cyc(4);
    chk_val("gate in undervoltage", 4'h0, gateDrive);
    chk_val("step in undervoltage", 4'h0, peakLimitStep);
    chk_val("fault after restart", 4'h0, faultLatched);
    @(posedge clk);
    underVoltage <= 1'b0;
    soft_start();
  endtask

  // Period per line level, jitter spread and the latched line select.
  task automatic t_line();
    int base, lo, up;
    for (int li = 0; li < 2; li++) begin
      @(posedge clk);
      lineHighDetect <= li[0];
      measure();
      measure();
      chk_val("line select", {3'h0, li[0]}, lineHighSel);
      base = li ? int'(PER_HIGH) : int'(PER_LOW);
      lo = 9999;
      up = 0;
      repeat (6) begin
        measure();
        chk_range("period", base - int'(JIT_SPAN) - 2, base + int'(JIT_SPAN) + 4, per);
        lo = (per < lo) ? per : lo;
        up = (per > up) ? per : up;
      end
      chk_range("jitter spread", 8, 2 * int'(JIT_SPAN) + 6, up - lo);
    end
  endtask

  // On-time against the sense trip, blanking and slope start, at high line.
  task automatic t_pulse();
    peakDelay = 8'h01;
    measure();
    measure();
    chk_range("on-time in blanking", 16, 22, onT);
    peakDelay = 8'hff;
    measure();
    measure();
    chk_range("slope start", 202, 231, slopeAt);
    peakDelay = 8'h28;
    measure();
    measure();
    chk_range("on-time at peak", 41, 46, onT);
    valleyOn = 1'b0;
    measure();
    measure();
    chk_range("period without valley", int'(PER_HIGH) - int'(JIT_SPAN) + int'(HOLD_CYC) - 2,
      int'(PER_HIGH) + int'(JIT_SPAN) + int'(HOLD_CYC) + 6, per);
    valleyOn = 1'b1;
  endtask

  // Burst entry and exit hysteresis, then PFM stretching with a floor.
  task automatic t_burst_pfm();
    @(posedge clk);
    fbAboveGreenExit <= 1'b0;
    fbBelowGreenEntry <= 1'b1;
    fbAboveBurstExit <= 1'b0;
    fbBelowBurstEntry <= 1'b1;
    cyc(4);
    quiet(1500, hi);
    chk_range("gate in burst", 0, 0, hi);
    @(posedge clk);
    fbBelowBurstEntry <= 1'b0;
    quiet(1500, hi);
    chk_range("gate inside hysteresis", 0, 0, hi);
    @(posedge clk);
    fbAboveBurstExit <= 1'b1;
    quiet(2000, hi);
    chk_range("gate after burst exit", 1, 2000, hi);
    repeat (25) measure();
    chk_range("stretched period", int'(PER_HIGH) + int'(JIT_SPAN) + 8,
      int'(PER_MIN_FREQ) + 4, per);
    @(posedge clk);
    fbBelowGreenEntry <= 1'b0;
    fbAboveGreenExit <= 1'b1;
  endtask

  // A per-cycle trip level held on: counts turn-ons before the latch.
  task automatic t_trip_cycles(input bit sel);
    int n, rises;
    logic prev;
    n = 0;
    rises = 0;
    prev = 1'b0;
    @(posedge clk);
    if (sel) csAboveRectShort <= 1'b1;
    else plateauOvervolt <= 1'b1;
    while (faultLatched !== 1'b1 && n < 12000) begin
      cyc(1);
      n++;
      if (gateDrive === 1'b1 && prev === 1'b0) rises++;
      prev = gateDrive;
    end
    chk_range("turn-ons before trip", 6, 8, rises);
    // A trip that never latched leaves the bench in an unknown state.
    if (n >= 12000) begin
      finish_test();
    end
    @(posedge clk);
    csAboveRectShort <= 1'b0;
    plateauOvervolt <= 1'b0;
    quiet(1500, hi);
    chk_range("gate while latched", 0, 0, hi);
    chk_val("fault held", 4'h1, faultLatched);
    restart();
  endtask

  // A timed trip level: a short overload burst must not latch, a long hold must.
  task automatic t_trip_time(input bit sel, input int lim);
    int n;
    n = 0;
    if (!sel) begin
      @(posedge clk);
      fbAboveOverload <= 1'b1;
      repeat (lim - 10) @(posedge clk);
      fbAboveOverload <= 1'b0;
      cyc(8);
      chk_val("early overload fault", 4'h0, faultLatched);
    end
    @(posedge clk);
    if (sel) csAboveExtThermal <= 1'b1;
    else fbAboveOverload <= 1'b1;
    while (faultLatched !== 1'b1 && n < lim + 40) begin cyc(1); n++; end
    chk_range("debounce cycles", lim - 1, lim + 6, n);
    // A timed trip that never latched ends the run.
    if (n >= lim + 40) begin
      finish_test();
    end
    @(posedge clk);
    csAboveExtThermal <= 1'b0;
    fbAboveOverload <= 1'b0;
    restart();
  endtask

  // Die fault follows the hot and cooled flags and blocks the gate.
  task automatic t_die();
    @(posedge clk);
    dieHot <= 1'b1;
    quiet(1000, hi);
    chk_range("gate while hot", 0, 3, hi);
    chk_val("die fault set", 4'h1, dieFault);
    @(posedge clk);
    dieHot <= 1'b0;
    cyc(6);
    chk_val("die fault before cool", 4'h1, dieFault);
    @(posedge clk);
    dieCooled <= 1'b1;
    cyc(6);
    chk_val("die fault after cool", 4'h0, dieFault);
    @(posedge clk);
    dieCooled <= 1'b0;
    quiet(1000, hi);
    chk_range("gate after cool", 1, 1000, hi);
  endtask

  // Watchdog: a hang counts as a mismatch and goes to the report.
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("unexpected run length: expected under 100000, seen more");
    finish_test();
  end

  // Main sequence: feedback high, no trips, high line.
  initial begin
    errors = 0;
    n_checks = 0;
    {arst_n, supplyGood, underVoltage, fbBelowGreenEntry, fbBelowBurstEntry} = 5'h00;
    {fbAboveOverload, csAboveExtThermal, csAboveRectShort, plateauOvervolt} = 4'h0;
    {dieHot, dieCooled, fbAboveGreenExit, fbAboveBurstExit} = 4'h3;
    lineHighDetect = 1'b1;
    valleyOn = 1'b1;
    peakDelay = 8'h28;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    quiet(300, hi);
    chk_range("gate before supply good", 0, 0, hi);
    @(posedge clk);
    supplyGood <= 1'b1;
    soft_start();
    t_line();
    t_pulse();
    t_burst_pfm();
    t_trip_cycles(1'b0);
    t_trip_cycles(1'b1);
    t_trip_time(1'b0, OVL_C);
    t_trip_time(1'b1, EXT_C);
    t_die();
    finish_test();
  end
endmodule
`default_nettype wire

// File: fcp_pkg.sv
// Operation
// - Stay idle, gate low, until supply good.
// - Undervoltage stops switching, returns to idle.
// - Soft start raises peak limit stepwise.
// - Fixed 65 kHz high line, else 90 kHz.
// - PFM below green entry, exit above green exit.
// - PFM lowers frequency, floor at 25 kHz.
// - Below burst entry: burst, gate off.
// - Burst resumes only above burst exit level.
// - QR variant waits valley before turn-on.
// - Plateau overvoltage seven cycles trips fault.
// - Overload level beyond 60 ms trips fault.
// - Die hot sets fault, clears on cool.
// - External thermal persisting 48 ms trips fault.
// - Rectifier short seven cycles trips fault.
// - Peak limit ends on-time each cycle.
// - Blank current sense 400 ns after turn-on.
// - Jitter period six percent at 30 Hz; 36 cycles at both lines, and +91 on the first sweep after reset.
// - Slope ramp only beyond 35 percent duty.
package fcp_pkg;
  // Core clock rate.
  localparam int CLK_HZ = 40_000_000;
  // Switching frequencies.
  localparam int FREQ_HIGH_LINE_HZ = 65_000;
  localparam int FREQ_LOW_LINE_HZ = 90_000;
  localparam int FREQ_MIN_HZ = 25_000;
  localparam int JITTER_HZ = 30;
  localparam int JITTER_PCT = 6;
  // Periods in core cycles, rounded down.
  localparam logic [11:0] PER_HIGH = 12'(CLK_HZ / FREQ_HIGH_LINE_HZ);
  localparam logic [11:0] PER_LOW = 12'(CLK_HZ / FREQ_LOW_LINE_HZ);
  localparam logic [11:0] PER_MIN_FREQ = 12'(CLK_HZ / FREQ_MIN_HZ);
  // Jitter excursion in cycles around the base period.
  localparam logic [6:0] JIT_SPAN = 7'(CLK_HZ / FREQ_HIGH_LINE_HZ * JITTER_PCT / 100);
  localparam int JIT_STEP_DEF = CLK_HZ / JITTER_HZ / (4 * CLK_HZ / FREQ_HIGH_LINE_HZ * JITTER_PCT / 100);
  // Blanking after turn-on: 400 ns, rounded up.
  localparam int BLANK_NS = 400;
  localparam logic [4:0] BLANK_CYC = 5'((BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  // Longest valley wait: 5 us, rounded down.
  localparam int HOLD_US = 5;
  localparam logic [7:0] HOLD_CYC = 8'(HOLD_US * (CLK_HZ / 1_000_000));
  // Soft start: 6 ms shared over sixteen steps.
  localparam int SS_MS = 6;
  localparam int SS_STEPS = 16;
  localparam int SS_STEP_DEF = SS_MS * (CLK_HZ / 1000) / SS_STEPS;
  // Overload and external thermal debounce.
  localparam int OVL_MS = 60;
  localparam int OVL_DEF = OVL_MS * (CLK_HZ / 1000);
  localparam int EXT_MS = 48;
  localparam int EXT_DEF = EXT_MS * (CLK_HZ / 1000);
  // Consecutive cycles for plateau and rectifier short trips.
  localparam logic [2:0] TRIP_CYCLES = 3'h7;
  // Duty figures in percent.
  localparam logic [6:0] DUTY_MAX_PCT = 7'h50;
  localparam logic [6:0] SLOPE_PCT = 7'h23;
  // PFM period growth per switching cycle.
  localparam logic [11:0] PFM_STEP = 12'h008;
  localparam int CNT_W = 22;
  // Synchronised input vector positions.
  localparam int IN_W = 14;
  localparam int I_SUPPLY = 0;
  localparam int I_UNDERV = 1;
  localparam int I_GREEN_IN = 2;
  localparam int I_GREEN_OUT = 3;
  localparam int I_BURST_IN = 4;
  localparam int I_BURST_OUT = 5;
  localparam int I_OVERLOAD = 6;
  localparam int I_PEAK = 7;
  localparam int I_EXT_HOT = 8;
  localparam int I_SHORT = 9;
  localparam int I_PLATEAU = 10;
  localparam int I_VALLEY = 11;
  localparam int I_LINE = 12;
  localparam int I_DIE_HOT = 13;
  // Sequencer states and load modes.
  typedef enum logic [1:0] {ST_IDLE, ST_SOFT, ST_RUN, ST_FAULT} fcp_state_e;
  typedef enum logic [1:0] {MD_FIXED, MD_PFM, MD_BURST} fcp_mode_e;
endpackage

// File: fcp_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Power switch and sense comparators: sense current ramps while the gate is on.
module fcp_switch_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic gateDrive,
  input wire logic [7:0] peakDelay,
  input wire logic valleyOn,
  output logic csAbovePeakLimit,
  output logic valleyDetect
);
  // Cycles spent in the present on-phase and off-phase.
  logic [7:0] onCnt;
  logic [7:0] offCnt;
  // Outputs move just after an edge, as a comparator chain would.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      onCnt <= 8'h00;
      offCnt <= 8'h00;
      csAbovePeakLimit <= 1'b0;
      valleyDetect <= 1'b0;
    end else begin
      onCnt <= gateDrive ? onCnt + 8'h01 : 8'h00;
      offCnt <= (gateDrive || offCnt == 8'hff) ? (gateDrive ? 8'h00 : offCnt) : offCnt + 8'h01;
      // Sense trips once the ramp has run peakDelay cycles.
      csAbovePeakLimit <= gateDrive && (onCnt >= peakDelay);
      // Demagnetisation lasts 40 cycles; a valley can be withheld to force the hold timeout.
      valleyDetect <= valleyOn && !gateDrive && (offCnt >= 8'h28);
    end
  end
endmodule
`default_nettype wire
